// ==== tb/sfcb_checker.sv ====
/* Concurrent checks on the configuration bank ports.
   Assumes one clock, mclk_in, and a synchronous active-high reset. */
`timescale 1ns/100ps
`include "sfcb_defines.vh"
module sfcb_checker (
    input wire mclk_in,
    input wire sys_rst_in,
    input wire [11:0] avs_address_in,
    input wire avs_read_in,
    input wire avs_write_in,
    input wire [31:0] avs_writedata_in,
    input wire [3:0] avs_byteenable_in,
    input wire [31:0] avs_readdata_out,
    input wire avs_waitrequest_out,
    input wire page_wr_in,
    input wire [3:0] page_sel_in,
    input wire [7:0] page_offset_in,
    input wire [7:0] page_wdata_in,
    input wire bridge_supply_on_out,
    input wire [1:0] bridge_level_sel_out,
    input wire [4:0] pressure_gain_code_out,
    input wire [3:0] temp_mux_sel_out,
    input wire internal_temp_sense_out,
    input wire temp_mux_reserved_out,
    input wire [2:0] temp_excite_current_out,
    input wire temp_excite_off_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (sys_rst_in);
    // ==========================================================
    // Write sequences, handshake and output decode checks, and visible write effects
    // ==========================================================
    // A bus write to the bridge register taken while no answer is pending.
    sequence bus_bridge_wr;
        avs_write_in && avs_waitrequest_out && avs_byteenable_in[0]
            && avs_address_in == `SFCB_A_BRIDGE;
    endsequence
    // A page-port write to the pressure gain offset with no bus write in the same cycle.
    sequence page_pgain_wr;
        page_wr_in && page_sel_in == 4'h2 && page_offset_in == 8'h47 && !avs_write_in;
    endsequence
    a_wait_answer: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
        |=> !avs_waitrequest_out) else $error("no answer one cycle after a request");
    a_wait_single: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("answer lasted longer than one cycle");
    a_read_upper: assert property (!avs_waitrequest_out |-> avs_readdata_out[31:8] == 24'h0)
        else $error("read data upper bytes not zero");
    a_level_map: assert property (bridge_level_sel_out != 2'h3)
        else $error("bridge level code 3 passed through");
    a_mux_internal: assert property (internal_temp_sense_out == (temp_mux_sel_out == 4'h3))
        else $error("internal sensor flag wrong");
    a_mux_reserved: assert property (temp_mux_reserved_out ==
        (temp_mux_sel_out != 4'h0 && temp_mux_sel_out != 4'h3)) else $error("reserved flag wrong");
    a_excite_off: assert property (temp_excite_off_out == temp_excite_current_out[2])
        else $error("excitation off flag differs from code bit 2");
    a_bus_update: assert property (bus_bridge_wr |-> ##2
        bridge_supply_on_out == $past(avs_writedata_in[0], 2)) else $error("bridge on not updated");
    a_page_update: assert property (page_pgain_wr |-> ##2
        pressure_gain_code_out == $past(page_wdata_in[4:0], 2)) else $error("page write lost");
endmodule // sfcb_checker

bind sfcb_config_bank sfcb_checker chk_u (.mclk_in, .sys_rst_in, .avs_address_in, .avs_read_in,
    .avs_write_in, .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out,
    .page_wr_in, .page_sel_in, .page_offset_in, .page_wdata_in, .bridge_supply_on_out,
    .bridge_level_sel_out, .pressure_gain_code_out, .temp_mux_sel_out, .internal_temp_sense_out,
    .temp_mux_reserved_out, .temp_excite_current_out, .temp_excite_off_out);

// ==== tb/sfcb_config_bank_tb_top.sv ====
/* Self-checking bench for the configuration bank.
   Assumes the Avalon slave answers after one wait state. */
`timescale 1ns/100ps
`include "sfcb_defines.vh"
module sfcb_config_bank_tb_top;
    logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, pw = 1'b0;
    logic [11:0] addr = 12'h000;
    logic [31:0] wd = 32'h0, q;
    logic [3:0] be = 4'h1, ps = 4'h0;
    logic [7:0] po = 8'h00, pd = 8'h00;
    wire [31:0] rdat;
    wire [7:0] prd;
    wire wreq, on, pf, tf, ints, res, off, se;
    wire [1:0] lvl, tg;
    wire [4:0] pg;
    wire [3:0] mux;
    wire [2:0] cur;
    wire [22:0] outs = {on, lvl, pg, pf, tg, tf, mux, ints, res, cur, off, se};
    int fail_count = 0, tests_run = 0;
    sfcb_config_bank dut_u (.mclk_in(clk), .sys_rst_in(rst), .avs_address_in(addr),
        .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(be),
        .avs_readdata_out(rdat), .avs_waitrequest_out(wreq), .page_wr_in(pw), .page_sel_in(ps),
        .page_offset_in(po), .page_wdata_in(pd), .page_rdata_out(prd), .bridge_supply_on_out(on),
        .bridge_level_sel_out(lvl), .pressure_gain_code_out(pg), .pressure_polarity_flip_out(pf),
        .temp_gain_code_out(tg), .temp_polarity_flip_out(tf), .temp_mux_sel_out(mux),
        .internal_temp_sense_out(ints), .temp_mux_reserved_out(res),
        .temp_excite_current_out(cur), .temp_excite_off_out(off), .temp_single_ended_out(se));
    // ==========================================================
    // Shared tasks
    // ==========================================================
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask
    // One Avalon transfer, held until waitrequest is sampled low.
    task bus(input logic w, input logic [11:0] a, input logic [7:0] d);
        int n;
        @(posedge clk);
        rd <= !w;
        wr <= w;
        addr <= a;
        wd <= {24'h0, d};
        n = 0;
        do begin @(posedge clk); n++; end while (wreq !== 1'b0 && n < 20);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        if (n >= 20) chk("answer", 1, 0);
    endtask
    task wrc(input logic [11:0] a, input logic [7:0] d, input logic [7:0] e);
        bus(1'b1, a, d);
        bus(1'b0, a, 8'h00);
        chk("readback", e, q);
    endtask
    task pwr(input logic [3:0] s, input logic [7:0] o, input logic [7:0] d);
        @(posedge clk);
        pw <= 1'b1;
        ps <= s;
        po <= o;
        pd <= d;
        @(posedge clk);
        pw <= 1'b0;
        @(posedge clk);
        @(negedge clk);
    endtask
    task close_out;
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // ==========================================================
    // Scenarios
    // ==========================================================
    task t_reset;
        logic [11:0] a [5] = '{`SFCB_A_BRIDGE, `SFCB_A_PGAIN, `SFCB_A_TGAIN, `SFCB_A_TCHAN,
            `SFCB_A_TSTYLE};
        logic [7:0] r [5] = '{8'h00, 8'h00, 8'h00, 8'h40, 8'h00};
        chk("reset outputs", 23'h000012, outs);
        for (int i = 0; i < 5; i++) begin
            bus(1'b0, a[i], 8'h00);
            chk("reset value", r[i], q);
        end
        wrc(12'h004, 8'hff, 8'h00);
    endtask
    task t_bridge;
        for (int i = 0; i < 4; i++) begin
            wrc(`SFCB_A_BRIDGE, 8'hf9 | (i << 1), 8'h01 | (i << 1));
            chk("level", (i == 3) ? 2 : i, lvl);
            chk("bridge on", 1, on);
        end
        be <= 4'h0;
        wrc(`SFCB_A_BRIDGE, 8'h00, 8'h07);
        be <= 4'h1;
        wrc(`SFCB_A_BRIDGE, 8'h00, 8'h00);
        chk("bridge off", 0, on);
    endtask
    task t_gains;
        wrc(`SFCB_A_PGAIN, 8'hff, 8'h9f);
        chk("pressure", 6'h3f, {pf, pg});
        wrc(`SFCB_A_PGAIN, 8'h60, 8'h00);
        wrc(`SFCB_A_TGAIN, 8'hff, 8'h83);
        chk("temp gain", 3'h7, {tf, tg});
        wrc(`SFCB_A_TGAIN, 8'h7c, 8'h00);
        chk("flips", 2'h0, {pf, tf});
    endtask
    task t_tchan;
        logic [3:0] m [3] = '{4'h0, 4'h3, 4'h9};
        for (int c = 0; c < 8; c++)
            for (int k = 0; k < 3; k++) begin
                wrc(`SFCB_A_TCHAN, {1'b1, c[2:0], m[k]}, {1'b0, c[2:0], m[k]});
                chk("current", {c[2:0], c[2]}, {cur, off});
                chk("mux", {m[k], k == 1, k == 2}, {mux, ints, res});
            end
    endtask
    task t_style;
        wrc(`SFCB_A_TSTYLE, 8'hff, 8'h01);
        chk("single ended", 1, se);
        wrc(`SFCB_A_TSTYLE, 8'hfe, 8'h00);
        chk("differential", 0, se);
    endtask
    task t_page;
        pwr(4'h2, 8'h46, 8'h05);
        pwr(4'h2, 8'h47, 8'h9f);
        pwr(4'h2, 8'h48, 8'h81);
        pwr(4'h2, 8'h4c, 8'h33);
        pwr(4'h3, 8'h46, 8'h00);
        pwr(4'h2, 8'h3a, 8'h01);
        chk("page outputs", 23'h6fd9cc, outs);
        pwr(4'h2, 8'h47, 8'h9f);
        chk("page read", 8'h9f, prd);
        bus(1'b0, `SFCB_A_TGAIN, 8'h00);
        chk("page to bus", 8'h81, q);
    endtask
    // Clock, watchdog and the main sequence.
    initial forever #25 clk = ~clk;
    initial begin
        #200000;
        fail_count++;
        close_out;
    end
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_reset;
        $display("reset test done");
        t_bridge;
        $display("bridge test done");
        t_gains;
        $display("gain test done");
        t_tchan;
        $display("temperature channel test done");
        t_style;
        $display("input style test done");
        t_page;
        $display("page port test done");
        close_out;
    end
endmodule // sfcb_config_bank_tb_top

// ==== verilog/sfcb_config_bank.v ====
/*
 * Sensor front-end configuration bank: byte-wide registers behind an
 * Avalon-MM slave, driving static analog control levels.
 * Assumes a synchronous Avalon master on mclk_in and one clock domain.
 */
// Implementation choice: register access over Avalon-MM.
// Operation
// - Bridge register bit 0 turns bridge excitation off (0) or on (1).
// - Bridge level bits 2:1: 00 2.5V, 01 2.0V, 1x 1.25V; reset 00.
// - Pressure gain code in bits 4:0, reset zero; bits 6:5 unused.
// - Pressure register bit 7 inverts pressure amplifier output; reset 0.
// - Temperature gain code in bits 1:0, reset zero; bits 6:2 unused.
// - Temperature gain bit 7 inverts temperature amplifier output; reset 0.
// - Input select 0000 routes external pins, 0011 internal sensor; others reserved.
// - Current 000 25uA, 001 50uA, 010 100uA, 011 500uA, bit6 off; reset 100.
// - Four registers also reached on page 2 at 0x46, 0x47, 0x48, 0x4C.
// - Input style register at 0x4000003A, bit 0 only, read-write, reset 0.
// - Input style 1 makes temperature mux single-ended, 0 differential.
`timescale 1ns/100ps
`include "sfcb_defines.vh"

module sfcb_config_bank (
    input wire mclk_in,
    input wire sys_rst_in,
    input wire [`SFCB_ADDR_W-1:0] avs_address_in,
    input wire avs_read_in,
    input wire avs_write_in,
    input wire [31:0] avs_writedata_in,
    input wire [3:0] avs_byteenable_in,
    output reg [31:0] avs_readdata_out,
    output reg avs_waitrequest_out,
    input wire page_wr_in,
    input wire [3:0] page_sel_in,
    input wire [7:0] page_offset_in,
    input wire [7:0] page_wdata_in,
    output reg [7:0] page_rdata_out,
    output reg bridge_supply_on_out,
    output reg [1:0] bridge_level_sel_out,
    output reg [4:0] pressure_gain_code_out,
    output reg pressure_polarity_flip_out,
    output reg [1:0] temp_gain_code_out,
    output reg temp_polarity_flip_out,
    output reg [3:0] temp_mux_sel_out,
    output reg internal_temp_sense_out,
    output reg temp_mux_reserved_out,
    output reg [2:0] temp_excite_current_out,
    output reg temp_excite_off_out,
    output reg temp_single_ended_out
);

    // ================================================================
    // Storage
    // ================================================================
    reg [7:0] bridge_q;
    reg [7:0] pgain_q;
    reg [7:0] tgain_q;
    reg [7:0] tchan_q;
    reg [7:0] tstyle_q;
    reg ack_q;
    reg [2:0] bus_sel;
    reg [2:0] pg_sel;
    reg [7:0] bus_rd;
    wire bus_req;
    wire bus_wr;
    wire pg_wr;
    wire [7:0] bus_wbyte;
    wire [1:0] level_d;

    // Map a bus byte address to a register number, 0 when unmapped.
    function [2:0] sfcb_bus_decode;
        input [`SFCB_ADDR_W-1:0] addr;
        begin
            case (addr)
                `SFCB_A_BRIDGE: sfcb_bus_decode = 3'h1;
                `SFCB_A_PGAIN: sfcb_bus_decode = 3'h2;
                `SFCB_A_TGAIN: sfcb_bus_decode = 3'h3;
                `SFCB_A_TCHAN: sfcb_bus_decode = 3'h4;
                `SFCB_A_TSTYLE: sfcb_bus_decode = 3'h5;
                default: sfcb_bus_decode = 3'h0;
            endcase
        end
    endfunction

    // Map a page and page offset to a register number, 0 when unmapped.
    function [2:0] sfcb_page_decode;
        input [3:0] page;
        input [7:0] offs;
        begin
            sfcb_page_decode = 3'h0;
            if (page == `SFCB_PAGE) begin
                case (offs)
                    `SFCB_PG_BRIDGE: sfcb_page_decode = 3'h1;
                    `SFCB_PG_PGAIN: sfcb_page_decode = 3'h2;
                    `SFCB_PG_TGAIN: sfcb_page_decode = 3'h3;
                    `SFCB_PG_TCHAN: sfcb_page_decode = 3'h4;
                    default: sfcb_page_decode = 3'h0;
                endcase
            end
        end
    endfunction

    // Request qualification: one wait cycle, answer on the second edge.
    assign bus_req = (avs_read_in | avs_write_in) & ~ack_q;
    assign bus_wr = avs_write_in & ~ack_q & avs_byteenable_in[0];
    assign pg_wr = page_wr_in;
    assign bus_wbyte = avs_writedata_in[7:0];

    // Decode and read multiplexer.
    always @* begin
        bus_sel = sfcb_bus_decode(avs_address_in);
        pg_sel = sfcb_page_decode(page_sel_in, page_offset_in);
        case (bus_sel)
            3'h1: bus_rd = bridge_q;
            3'h2: bus_rd = pgain_q;
            3'h3: bus_rd = tgain_q;
            3'h4: bus_rd = tchan_q;
            3'h5: bus_rd = tstyle_q;
            default: bus_rd = 8'h00;
        endcase
    end

    // ================================================================
    // Register writes; the bus wins over the page port on a collision.
    // ================================================================
    always @(posedge mclk_in) begin
        if (sys_rst_in) begin
            bridge_q <= `SFCB_RST_BRIDGE;
            pgain_q <= `SFCB_RST_PGAIN;
            tgain_q <= `SFCB_RST_TGAIN;
            tchan_q <= `SFCB_RST_TCHAN;
            tstyle_q <= `SFCB_RST_TSTYLE;
        end else begin
            if (bus_wr && bus_sel == 3'h1)
                bridge_q <= bus_wbyte & `SFCB_MSK_BRIDGE;
            else if (pg_wr && pg_sel == 3'h1)
                bridge_q <= page_wdata_in & `SFCB_MSK_BRIDGE;
            if (bus_wr && bus_sel == 3'h2)
                pgain_q <= bus_wbyte & `SFCB_MSK_PGAIN;
            else if (pg_wr && pg_sel == 3'h2)
                pgain_q <= page_wdata_in & `SFCB_MSK_PGAIN;
            if (bus_wr && bus_sel == 3'h3)
                tgain_q <= bus_wbyte & `SFCB_MSK_TGAIN;
            else if (pg_wr && pg_sel == 3'h3)
                tgain_q <= page_wdata_in & `SFCB_MSK_TGAIN;
            if (bus_wr && bus_sel == 3'h4)
                tchan_q <= bus_wbyte & `SFCB_MSK_TCHAN;
            else if (pg_wr && pg_sel == 3'h4)
                tchan_q <= page_wdata_in & `SFCB_MSK_TCHAN;
            if (bus_wr && bus_sel == 3'h5)
                tstyle_q <= bus_wbyte & `SFCB_MSK_TSTYLE;
        end
    end

    // Avalon handshake and read data, plus page-port read data.
    always @(posedge mclk_in) begin
        if (sys_rst_in) begin
            ack_q <= 1'b0;
            avs_waitrequest_out <= 1'b1;
            avs_readdata_out <= 32'h00000000;
            page_rdata_out <= 8'h00;
        end else begin
            ack_q <= bus_req;
            avs_waitrequest_out <= ~bus_req;
            if (bus_req)
                avs_readdata_out <= {24'h000000, bus_rd};
            case (pg_sel)
                3'h1: page_rdata_out <= bridge_q;
                3'h2: page_rdata_out <= pgain_q;
                3'h3: page_rdata_out <= tgain_q;
                3'h4: page_rdata_out <= tchan_q;
                default: page_rdata_out <= 8'h00;
            endcase
        end
    end

    // Bridge level: codes 10 and 11 both select the lowest supply.
    assign level_d = bridge_q[2] ? `SFCB_LVL_1V25 : bridge_q[2:1];

    // ================================================================
    // Analog control outputs, registered one stage from storage.
    // ================================================================
    always @(posedge mclk_in) begin
        if (sys_rst_in) begin
            bridge_supply_on_out <= 1'b0;
            bridge_level_sel_out <= `SFCB_LVL_2V5;
            pressure_gain_code_out <= 5'h00;
            pressure_polarity_flip_out <= 1'b0;
            temp_gain_code_out <= 2'h0;
            temp_polarity_flip_out <= 1'b0;
            temp_mux_sel_out <= `SFCB_MUX_EXT;
            internal_temp_sense_out <= 1'b0;
            temp_mux_reserved_out <= 1'b0;
            temp_excite_current_out <= `SFCB_CUR_OFF;
            temp_excite_off_out <= 1'b1;
            temp_single_ended_out <= 1'b0;
        end else begin
            bridge_supply_on_out <= bridge_q[0];
            bridge_level_sel_out <= level_d;
            pressure_gain_code_out <= pgain_q[4:0];
            pressure_polarity_flip_out <= pgain_q[7];
            temp_gain_code_out <= tgain_q[1:0];
            temp_polarity_flip_out <= tgain_q[7];
            temp_mux_sel_out <= tchan_q[3:0];
            internal_temp_sense_out <= (tchan_q[3:0] == `SFCB_MUX_INT);
            temp_mux_reserved_out <= (tchan_q[3:0] != `SFCB_MUX_EXT) &&
                (tchan_q[3:0] != `SFCB_MUX_INT);
            temp_excite_current_out <= tchan_q[6:4];
            temp_excite_off_out <= tchan_q[6];
            temp_single_ended_out <= tstyle_q[0];
        end
    end

endmodule // sfcb_config_bank

// ==== verilog/sfcb_defines.vh ====
/*
 * Register map, field layouts and reset values of the sensor front-end
 * configuration bank. Assumes inclusion by bare name from the design file.
 */
`ifndef SFCB_DEFINES_VH
`define SFCB_DEFINES_VH

// ====================================================================
// Register addresses: EE map, page 2 offsets, and Avalon-MM byte addresses (word index times 4)
// ====================================================================
`define SFCB_EE_BRIDGE 32'h40000034
`define SFCB_EE_PGAIN 32'h40000035
`define SFCB_EE_TGAIN 32'h40000036
`define SFCB_EE_TCHAN 32'h40000037
`define SFCB_EE_TSTYLE 32'h4000003a
`define SFCB_PAGE 4'h2
`define SFCB_PG_BRIDGE 8'h46
`define SFCB_PG_PGAIN 8'h47
`define SFCB_PG_TGAIN 8'h48
`define SFCB_PG_TCHAN 8'h4c
`define SFCB_ADDR_W 12
`define SFCB_A_BRIDGE 12'h118
`define SFCB_A_PGAIN 12'h11c
`define SFCB_A_TGAIN 12'h120
`define SFCB_A_TCHAN 12'h130
`define SFCB_A_TSTYLE 12'h0e8

// ====================================================================
// Write masks and reset values
// ====================================================================
`define SFCB_MSK_BRIDGE 8'h07
`define SFCB_MSK_PGAIN 8'h9f
`define SFCB_MSK_TGAIN 8'h83
`define SFCB_MSK_TCHAN 8'h7f
`define SFCB_MSK_TSTYLE 8'h01
`define SFCB_RST_BRIDGE 8'h00
`define SFCB_RST_PGAIN 8'h00
`define SFCB_RST_TGAIN 8'h00
`define SFCB_RST_TCHAN 8'h40
`define SFCB_RST_TSTYLE 8'h00

// ====================================================================
// Field codes
// ====================================================================
`define SFCB_LVL_2V5 2'h0
`define SFCB_LVL_2V0 2'h1
`define SFCB_LVL_1V25 2'h2
`define SFCB_MUX_EXT 4'h0
`define SFCB_MUX_INT 4'h3
`define SFCB_CUR_OFF 3'h4

`endif
